// ---- design/l1asm_regs.vh ----
// Purpose: Constants for the layer-1 activation state machine.
// Assumes: Included by the design files of this block only.
// Notes:   Command and indication codes are 4-bit control channel values.
`ifndef L1ASM_REGS_VH
`define L1ASM_REGS_VH
`define L1ASM_CMD_TIM      4'h0
`define L1ASM_CMD_RES      4'h1
`define L1ASM_CMD_SSP      4'h2
`define L1ASM_CMD_SCP      4'h3
`define L1ASM_CMD_AR       4'h8
`define L1ASM_CMD_ARL      4'h9
`define L1ASM_CMD_DI       4'hF
`define L1ASM_IND_DR       4'h0
`define L1ASM_IND_PU       4'h7
`define L1ASM_IND_TMA      4'h2
`define L1ASM_IND_RSY      4'h4
`define L1ASM_IND_AR       4'h8
`define L1ASM_IND_ARL      4'h9
`define L1ASM_IND_AI       4'hC
`define L1ASM_IND_AIL      4'hD
`define L1ASM_IND_DC       4'hF
`define L1ASM_RX_I0        2'h0
`define L1ASM_RX_I2        2'h1
`define L1ASM_RX_I4        2'h2
`define L1ASM_RX_IX        2'h3
`define L1ASM_TX_I0        3'h0
`define L1ASM_TX_I1W       3'h1
`define L1ASM_TX_I1        3'h2
`define L1ASM_TX_I3        3'h3
`define L1ASM_TX_IT1       3'h4
`define L1ASM_TX_IT2       3'h5
`define L1ASM_USER_IDLE    8'hFF
`endif

// ---- design/l1asm_sync.v ----
// Purpose: Edge and change detector for the receive info class.
// Assumes: Inputs are synchronous to mclk_i.
// Notes:   Flags a change of the classified line signal for one cycle.
`timescale 1ns/10ps
`default_nettype none
module l1asm_sync #(
	parameter W = 2
) (
	// Clock and reset
	input  wire         mclk_i,
	input  wire         rst_n_i,
	// Value in
	input  wire [W-1:0] val_i,
	// Registered value and change pulse
	output reg  [W-1:0] val_o,
	output reg          chg_o
);
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			val_o <= {W{1'b0}};
			chg_o <= 1'b0;
		end else begin
			chg_o <= (val_i != val_o);
			val_o <= val_i;
		end
	end
endmodule // l1asm_sync
`default_nettype wire

// ---- design/l1asm_top.v ----
// Purpose: Layer-1 activation and deactivation control, terminal side.
// Assumes: Line levels and sync come from the receiver datapath; the class is decoded here.
// Notes:   Software mode passes commands and status straight through.
//
// Overview of operation
// [R1] User channels transparent only when activated.
// [R2] Internal machine after reset, commanded via channel.
// [R3] Software selects bypass and sends timing code.
// [R4] Bypass: software drives transmit, reads status.
// [R5] New indication raises control channel interrupt.
// [R6] Reset or info 0 enters reset-pending.
// [R7] Deactivated accepts line or bus activation.
// [R8] Power-up keeps line off, clocks run.
// [R9] Activation request sends wake until info 2; the code stops on any signal other than info 0.
// [R10] Level detect while signal seen, unsynchronised.
// [R11] Synchronised with info 2 sends info 1.
// [R12] Synchronised with info 4 activates, info 3.
// [R13] Local loop: info 1, info 3, transparent.
// [R14] Pulse commands enter test mode.
// [R15] Software resets after long resync timeout.
// [R16] Reset command idles, sends info 0.
// [R17] Upstream command codes as listed.
// [R18] Receiver classifies info 0, 2, 4, X.
// [R19] Pin or soft reset acts as reset command.
// [R20] Reset events held two data clocks.
// [R21] Downstream indication codes as listed.
// [R22] Deactivation confirm powers down line, bus.
// [R23] Power-up indication with interrupt after clocks.
// [R24] Bypass status change raises maskable interrupt.
// [R25] Each state drives its own indication.
`timescale 1ns/10ps
`default_nettype none
`include "l1asm_regs.vh"
module l1asm_top (
	// Clock and reset
	input  wire       mclk_i,
	input  wire       rst_n_i,
	// Control channel from layer 2
	input  wire [3:0] outgoing_command_code_i,
	input  wire       software_reset_i,
	// Configuration
	input  wire       software_layer1_select_i,
	input  wire       clock_stop_in_powerdown_i,
	input  wire       receiver_irq_mask_i,
	input  wire [2:0] transceiver_command_i,
	input  wire       status_read_i,
	input  wire       incoming_read_i,
	input  wire       bus_clocks_running_i,
	// Receiver datapath
	input  wire       rx_level_i,
	input  wire       rx_synced_i,
	input  wire       rx_scrambled_ones_i,
	input  wire       rx_bursts_4k_i,
	// User channels
	input  wire [7:0] line_b1_i,
	input  wire [7:0] line_b2_i,
	output reg  [7:0] bus_b1_o,
	output reg  [7:0] bus_b2_o,
	// Line control
	output reg  [2:0] tx_info_o,
	output reg        local_loop_o,
	output reg        line_powerdown_o,
	output reg        bus_powerdown_o,
	// Control channel to layer 2
	output reg  [3:0] incoming_command_o,
	output reg        control_channel_change_irq_o,
	output reg  [1:0] transceiver_status_o,
	output reg        receiver_change_irq_o
);
	localparam ST_RSTPEND = 4'h0;
	localparam ST_DEACT   = 4'h1;
	localparam ST_PWRUP   = 4'h2;
	localparam ST_PENDACT = 4'h3;
	localparam ST_LVLDET  = 4'h4;
	localparam ST_SYNC    = 4'h5;
	localparam ST_ACT     = 4'h6;
	localparam ST_L3PEND  = 4'h7;
	localparam ST_L3SYNC  = 4'h8;
	localparam ST_L3ACT   = 4'h9;
	localparam ST_TEST    = 4'hA;
	localparam ST_RESET   = 4'hB;
	localparam ST_DC      = 4'hC;

	reg  [3:0] state;
	reg  [3:0] next_state;
	reg        test_cont;
	reg        next_test_cont;
	reg  [3:0] next_ind;
	reg  [2:0] next_tx;
	reg  [1:0] rx_class;
	wire [1:0] rx_class_q;
	wire       rx_chg;
	wire       bypass;
	wire       any_reset;

	// Bypass needs both the select bit and a timing code from software.
	assign bypass = software_layer1_select_i &&
		(outgoing_command_code_i == `L1ASM_CMD_TIM); // [R3] [R4]
	// Soft reset acts as the reset command, except in bypass, where the state is held and the soft reset has no effect.
	assign any_reset = software_reset_i ||
		(outgoing_command_code_i == `L1ASM_CMD_RES); // [R19] [R16] [R17]

	// Line signal classification.
	always @* begin
		if (!rx_level_i)
			rx_class = `L1ASM_RX_I0; // [R18]
		else if (rx_bursts_4k_i && rx_scrambled_ones_i)
			rx_class = `L1ASM_RX_I2;
		else if (rx_bursts_4k_i)
			rx_class = `L1ASM_RX_I4;
		else
			rx_class = `L1ASM_RX_IX;
	end

	l1asm_sync #(
		.W(2)
	) u_rxchg (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.val_i   (rx_class),
		.val_o   (rx_class_q),
		.chg_o   (rx_chg)
	);

	always @* begin
		next_state     = state;
		next_test_cont = test_cont;
		case (state)
		ST_RSTPEND: begin
			// Terminal activation refused until deactivation indication.
			if (outgoing_command_code_i == `L1ASM_CMD_DI) // [R6]
				next_state = ST_DEACT;
		end
		ST_DEACT, ST_DC: begin
			if (rx_class != `L1ASM_RX_I0) // [R7]
				next_state = ST_LVLDET;
			else if (outgoing_command_code_i == `L1ASM_CMD_AR)
				next_state = ST_PENDACT;
			else if (outgoing_command_code_i == `L1ASM_CMD_ARL)
				next_state = ST_L3PEND;
			else if (outgoing_command_code_i == `L1ASM_CMD_TIM)
				next_state = ST_PWRUP;
			else if (outgoing_command_code_i == `L1ASM_CMD_DI &&
				state == ST_DEACT)
				next_state = ST_DC; // [R22]
		end
		ST_PWRUP: begin
			if (rx_class != `L1ASM_RX_I0) // [R8]
				next_state = ST_LVLDET;
			else if (outgoing_command_code_i == `L1ASM_CMD_AR)
				next_state = ST_PENDACT;
			else if (outgoing_command_code_i == `L1ASM_CMD_ARL)
				next_state = ST_L3PEND;
			else if (outgoing_command_code_i == `L1ASM_CMD_DI)
				next_state = ST_DEACT;
		end
		ST_PENDACT: begin
			if (rx_class != `L1ASM_RX_I0) // [R9]
				next_state = ST_LVLDET;
		end
		ST_LVLDET: begin
			if (rx_class == `L1ASM_RX_I0)
				next_state = ST_RSTPEND; // [R6]
			else if (rx_synced_i && rx_class == `L1ASM_RX_I2)
				next_state = ST_SYNC; // [R10] [R11]
			else if (rx_synced_i && rx_class == `L1ASM_RX_I4)
				next_state = ST_ACT; // [R12]
		end
		ST_SYNC, ST_ACT: begin
			if (rx_class == `L1ASM_RX_I0)
				next_state = ST_RSTPEND;
			else if (!rx_synced_i)
				next_state = ST_LVLDET;
			else if (rx_class == `L1ASM_RX_I4)
				next_state = ST_ACT; // [R12]
			else if (rx_class == `L1ASM_RX_I2)
				next_state = ST_SYNC; // [R11]
		end
		ST_L3PEND: begin
			if (rx_synced_i) // [R13]
				next_state = ST_L3SYNC;
		end
		ST_L3SYNC: begin
			if (rx_synced_i && rx_class == `L1ASM_RX_I4) // [R13]
				next_state = ST_L3ACT;
		end
		ST_L3ACT: begin
			if (!rx_synced_i)
				next_state = ST_L3SYNC;
		end
		ST_TEST, ST_RESET: begin
			if (outgoing_command_code_i == `L1ASM_CMD_DI)
				next_state = ST_DEACT;
		end
		default: next_state = ST_RSTPEND;
		endcase
		// Test commands are taken from any state.
		if (outgoing_command_code_i == `L1ASM_CMD_SSP) begin // [R14]
			next_state     = ST_TEST;
			next_test_cont = 1'b0;
		end else if (outgoing_command_code_i == `L1ASM_CMD_SCP) begin
			next_state     = ST_TEST;
			next_test_cont = 1'b1;
		end
		// Loop and test states leave to deactivated on the DI command.
		if ((state == ST_L3PEND || state == ST_L3SYNC ||
			state == ST_L3ACT) &&
			outgoing_command_code_i == `L1ASM_CMD_DI)
			next_state = ST_DEACT;
		if (any_reset)
			next_state = ST_RESET; // [R16] [R19]
	end

	// Per-state indication and line info.
	always @* begin
		next_ind = `L1ASM_IND_DR;
		next_tx  = `L1ASM_TX_I0;
		case (state)
		ST_RSTPEND: next_ind = `L1ASM_IND_DR; // [R25] [R21]
		ST_DEACT:   next_ind = `L1ASM_IND_DR;
		ST_DC:      next_ind = `L1ASM_IND_DC; // [R22]
		ST_PWRUP:   next_ind = `L1ASM_IND_PU; // [R23]
		ST_PENDACT: begin
			next_ind = `L1ASM_IND_PU;
			next_tx  = `L1ASM_TX_I1W; // [R9]
		end
		ST_LVLDET:  next_ind = `L1ASM_IND_RSY; // [R10] [R25]
		ST_SYNC: begin
			next_ind = `L1ASM_IND_AR;
			next_tx  = `L1ASM_TX_I1; // [R11]
		end
		ST_ACT: begin
			next_ind = `L1ASM_IND_AI;
			next_tx  = `L1ASM_TX_I3; // [R12]
		end
		ST_L3PEND: begin
			next_ind = `L1ASM_IND_PU;
			next_tx  = `L1ASM_TX_I1; // [R13]
		end
		ST_L3SYNC: begin
			next_ind = `L1ASM_IND_ARL;
			next_tx  = `L1ASM_TX_I3;
		end
		ST_L3ACT: begin
			next_ind = `L1ASM_IND_AIL;
			next_tx  = `L1ASM_TX_I3;
		end
		ST_TEST: begin
			next_ind = `L1ASM_IND_TMA; // [R14]
			next_tx  = test_cont ? `L1ASM_TX_IT1 : `L1ASM_TX_IT2;
		end
		ST_RESET:   next_ind = `L1ASM_IND_DR; // [R16]
		default: begin
			next_ind = `L1ASM_IND_DR;
			next_tx  = `L1ASM_TX_I0;
		end
		endcase
		// In ST_PWRUP, power-up is only reported once the bus clocks run.
		if (state == ST_PWRUP && !bus_clocks_running_i)
			next_ind = `L1ASM_IND_DC;
		if (bypass)
			next_tx = transceiver_command_i; // [R4]
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state     <= ST_RSTPEND; // [R2] [R6]
			test_cont <= 1'b0;
		end else if (!bypass) begin
			state     <= next_state;
			test_cont <= next_test_cont;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bus_b1_o                     <= `L1ASM_USER_IDLE;
			bus_b2_o                     <= `L1ASM_USER_IDLE;
			tx_info_o                    <= `L1ASM_TX_I0;
			local_loop_o                 <= 1'b0;
			line_powerdown_o             <= 1'b0;
			bus_powerdown_o              <= 1'b0;
			incoming_command_o           <= `L1ASM_IND_DR;
			control_channel_change_irq_o <= 1'b0;
			transceiver_status_o         <= `L1ASM_RX_I0;
			receiver_change_irq_o        <= 1'b0;
		end else begin
			// Idle ones keep the bus quiet outside activation.
			if (!bypass && (state == ST_ACT || state == ST_L3ACT)) begin
				bus_b1_o <= line_b1_i; // [R1]
				bus_b2_o <= line_b2_i;
			end else begin
				bus_b1_o <= `L1ASM_USER_IDLE;
				bus_b2_o <= `L1ASM_USER_IDLE;
			end
			tx_info_o    <= next_tx;
			local_loop_o <= !bypass && (state == ST_L3PEND ||
				state == ST_L3SYNC || state == ST_L3ACT); // [R13]
			line_powerdown_o <= !bypass && state == ST_DC; // [R22]
			bus_powerdown_o  <= !bypass && state == ST_DC &&
				clock_stop_in_powerdown_i;
			if (!bypass) begin
				incoming_command_o <= next_ind; // [R25]
			end
			// Set wins over the read clear.
			if (!bypass && next_ind != incoming_command_o)
				control_channel_change_irq_o <= 1'b1; // [R5] [R23]
			else if (incoming_read_i)
				control_channel_change_irq_o <= 1'b0;
			transceiver_status_o <= rx_class_q; // [R24]
			if (bypass && rx_chg && !receiver_irq_mask_i)
				receiver_change_irq_o <= 1'b1; // [R24]
			else if (status_read_i)
				receiver_change_irq_o <= 1'b0;
		end
	end
endmodule // l1asm_top
`default_nettype wire

// ---- testbench/l1asm_lt_model.sv ----
// Purpose: Line termination seen through the receiver status levels.
// Assumes: Class 0 none, 1 sync ones, 2 data, 3 other.
// Notes:   In local loop the own transmit is seen, so the far side is ignored.
`timescale 1ns/10ps
`default_nettype none
module l1asm_lt_model (
	// Far side and loop
	input  wire logic [1:0] cls_i,
	input  wire logic       sync_i,
	input  wire logic       loop_i,
	input  wire logic [2:0] tx_i,
	// Receiver levels
	output wire logic       level_o,
	output wire logic       synced_o,
	output wire logic       ones_o,
	output wire logic       bursts_o
);
	wire logic [1:0] c = !loop_i ? cls_i : (tx_i == 3'h3) ? 2'h2 :
		(tx_i == 3'h2) ? 2'h1 : 2'h0;
	assign level_o  = c != 2'h0;
	assign synced_o = (sync_i || loop_i) && (c == 2'h1 || c == 2'h2);
	assign ones_o   = c == 2'h1;
	assign bursts_o = c == 2'h1 || c == 2'h2;
endmodule // l1asm_lt_model
`default_nettype wire

// ---- testbench/l1asm_properties.sv ----
// Purpose: Assertions on the ports of the activation state machine.
// Assumes: Bound to l1asm_top.
// Notes:   One cycle of slack where outputs are registered twice.
`timescale 1ns/10ps
`default_nettype none
module l1asm_chk (
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	// Inputs
	input wire logic [3:0] outgoing_command_code_i,
	input wire logic       software_reset_i,
	input wire logic       software_layer1_select_i,
	input wire logic       receiver_irq_mask_i,
	input wire logic [2:0] transceiver_command_i,
	// Outputs
	input wire logic [7:0] bus_b1_o,
	input wire logic [2:0] tx_info_o,
	input wire logic       local_loop_o,
	input wire logic [3:0] incoming_command_o,
	input wire logic       control_channel_change_irq_o,
	input wire logic [1:0] transceiver_status_o,
	input wire logic       receiver_change_irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [3:0] ind = incoming_command_o;
	wire logic       sm  = !software_layer1_select_i;
	wire logic       byp = !sm && outgoing_command_code_i == 4'h0;
	property p_rst; $rose(rst_n_i) |-> tx_info_o == 3'h0 && ind == 4'h0
		&& bus_b1_o == 8'hFF && !control_channel_change_irq_o; endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	property p_idle; sm && bus_b1_o != 8'hFF |-> ind inside {4'hC, 4'hD}
		|| $past(ind) inside {4'hC, 4'hD}; endproperty
	a_idle: assert property (p_idle) else $error("bus not idle");
	property p_srst; (sm && software_reset_i)[*3] |->
		tx_info_o == 3'h0 && bus_b1_o == 8'hFF; endproperty
	a_srst: assert property (p_srst) else $error("soft reset");
	property p_cic; $changed(ind) |->
		##[0:1] control_channel_change_irq_o; endproperty
	a_cic: assert property (p_cic) else $error("no cic irq");
	property p_ric; $past(byp) && byp && !receiver_irq_mask_i
		&& $changed(transceiver_status_o) |-> ##[0:1] receiver_change_irq_o;
	endproperty
	a_ric: assert property (p_ric) else $error("no rx irq");
	property p_tx; (byp && $stable(transceiver_command_i))[*3] |->
		tx_info_o == transceiver_command_i; endproperty
	a_tx: assert property (p_tx) else $error("bypass tx");
	property p_ai; sm && $past(sm) && ind == 4'hC |->
		tx_info_o == 3'h3; endproperty
	a_ai: assert property (p_ai) else $error("active tx");
	property p_loop; sm && $past(sm) && ind == 4'hD |->
		local_loop_o && tx_info_o == 3'h3; endproperty
	a_loop: assert property (p_loop) else $error("loop");
	property p_test; sm && $past(sm) && ind == 4'h2 |->
		tx_info_o inside {3'h4, 3'h5}; endproperty
	a_test: assert property (p_test) else $error("test tx");
endmodule // l1asm_chk
bind l1asm_top l1asm_chk l1asm_chk_i (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the activation state machine.
// Assumes: The line side is played by l1asm_lt_model.
// Notes:   Inputs change on rising edges, outputs are read on falling ones.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic       mclk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [3:0] outgoing_command_code_i = 4'h0;
	logic       software_reset_i = 1'b0;
	logic       software_layer1_select_i = 1'b0;
	logic       clock_stop_in_powerdown_i = 1'b1;
	logic       receiver_irq_mask_i = 1'b0;
	logic [2:0] transceiver_command_i = 3'h0;
	logic       status_read_i = 1'b0;
	logic       incoming_read_i = 1'b0;
	logic       bus_clocks_running_i = 1'b1;
	logic       rx_level_i, rx_synced_i, rx_scrambled_ones_i, rx_bursts_4k_i;
	logic [7:0] line_b1_i = 8'h5A;
	logic [7:0] line_b2_i = 8'hC3;
	logic [7:0] bus_b1_o, bus_b2_o;
	logic [2:0] tx_info_o;
	logic       local_loop_o, line_powerdown_o, bus_powerdown_o;
	logic [3:0] incoming_command_o;
	logic       control_channel_change_irq_o, receiver_change_irq_o;
	logic [1:0] transceiver_status_o;
	logic [1:0] cls = 2'h0;
	logic       sync = 1'b0;
	integer     failures = 0, n_checks = 0, cyc = 0;
	l1asm_top l1asm_top_i (.*);
	l1asm_lt_model l1asm_lt_model_i (.cls_i(cls), .sync_i(sync),
		.loop_i(local_loop_o), .tx_i(tx_info_o), .level_o(rx_level_i),
		.synced_o(rx_synced_i), .ones_o(rx_scrambled_ones_i),
		.bursts_o(rx_bursts_4k_i));
	initial forever #2 mclk_i = ~mclk_i;
	task automatic chk(input logic [7:0] v, input logic [7:0] e);
		n_checks = n_checks + 1;
		if (v !== e) begin
			failures = failures + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, v, e);
		end
	endtask
	task automatic cmd(input logic [3:0] c);
		@(posedge mclk_i) outgoing_command_code_i <= c;
	endtask
	task automatic wind(input logic [3:0] e);
		integer k;
		for (k = 0; k < 40 && incoming_command_o !== e; k = k + 1)
			@(negedge mclk_i);
		chk(incoming_command_o, e);
	endtask
	task automatic rd(input logic s);
		@(posedge mclk_i) {status_read_i, incoming_read_i} <= {s, !s};
		@(posedge mclk_i) {status_read_i, incoming_read_i} <= 2'b00;
		@(negedge mclk_i);
	endtask
	task automatic srst;
		@(posedge mclk_i) {software_reset_i, outgoing_command_code_i} <= 5'h1F;
		repeat (3) @(negedge mclk_i);
		chk(tx_info_o, 3'h0);
		chk(bus_b1_o, 8'hFF);
		// The reset state is left by a deactivation indication or a test command.
		@(posedge mclk_i) {software_reset_i, outgoing_command_code_i} <= 5'h0F;
		wind(4'hF);
	endtask
	task automatic t_act;
		chk(bus_b1_o, 8'hFF);
		cmd(4'h8);
		repeat (6) @(negedge mclk_i);
		chk(incoming_command_o, 4'h0);
		cmd(4'hF);
		wind(4'hF);
		chk(bus_powerdown_o, 1'b1);
		chk(line_powerdown_o, 1'b1);
		cmd(4'h8);
		wind(4'h7);
		chk(tx_info_o, 3'h1);
		chk(control_channel_change_irq_o, 1'b1);
		rd(1'b0);
		chk(control_channel_change_irq_o, 1'b0);
		@(posedge mclk_i) cls <= 2'h1;
		wind(4'h4);
		@(posedge mclk_i) sync <= 1'b1;
		wind(4'h8);
		chk(tx_info_o, 3'h2);
		@(posedge mclk_i) cls <= 2'h2;
		wind(4'hC);
		chk(tx_info_o, 3'h3);
		repeat (2) @(negedge mclk_i);
		chk(bus_b1_o, line_b1_i);
		@(posedge mclk_i) cls <= 2'h0;
		wind(4'h0);
		chk(bus_b1_o, 8'hFF);
		@(posedge mclk_i) sync <= 1'b0;
		$display("activation done");
	endtask
	task automatic t_loop;
		srst;
		cmd(4'h9);
		wind(4'hD);
		chk(local_loop_o, 1'b1);
		repeat (2) @(negedge mclk_i);
		chk(bus_b2_o, line_b2_i);
		srst;
		$display("loop done");
	endtask
	task automatic t_test;
		integer i;
		for (i = 2; i < 4; i = i + 1) begin
			cmd(i[3:0]);
			wind(4'h2);
			chk(tx_info_o, (i == 2) ? 3'h5 : 3'h4);
			srst;
		end
		$display("test mode done");
	endtask
	task automatic t_pu;
		@(posedge mclk_i) bus_clocks_running_i <= 1'b0;
		cmd(4'h0);
		repeat (6) @(negedge mclk_i);
		chk(incoming_command_o, 4'hF);
		rd(1'b0);
		@(posedge mclk_i) bus_clocks_running_i <= 1'b1;
		wind(4'h7);
		chk(control_channel_change_irq_o, 1'b1);
		chk(tx_info_o, 3'h0);
		$display("power-up done");
	endtask
	task automatic t_byp;
		integer i;
		@(posedge mclk_i) {software_layer1_select_i, sync} <= 2'b11;
		for (i = 0; i < 6; i = i + 1) begin
			@(posedge mclk_i) transceiver_command_i <= i[2:0];
			repeat (3) @(negedge mclk_i);
			chk(tx_info_o, i[2:0]);
		end
		for (i = 1; i < 5; i = i + 1) begin
			@(posedge mclk_i) cls <= i[1:0];
			repeat (3) @(negedge mclk_i);
			chk(transceiver_status_o, i[1:0]);
			chk(receiver_change_irq_o, 1'b1);
			rd(1'b1);
			chk(receiver_change_irq_o, 1'b0);
		end
		@(posedge mclk_i) {receiver_irq_mask_i, cls} <= 3'b110;
		repeat (3) @(negedge mclk_i);
		chk(receiver_change_irq_o, 1'b0);
		$display("bypass done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(negedge mclk_i);
		t_act;
		t_loop;
		t_test;
		t_pu;
		t_byp;
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
